// ==== verilog/mil_pkg.sv ====
// shared constants and carriers of the interrupt logic
// assumes one clock, one instruction cycle per core_clk_i edge
package mil_pkg;

  // =====================================================
  // control register bit positions
  localparam int unsigned CTL_GLB_BIT   = 7;
  localparam int unsigned CTL_PEIE_BIT  = 6;
  localparam int unsigned CTL_TOVE_BIT  = 5;
  localparam int unsigned CTL_EXTE_BIT  = 4;
  localparam int unsigned CTL_PCHE_BIT  = 3;
  localparam int unsigned CTL_TOVF_BIT  = 2;
  localparam int unsigned CTL_EXTF_BIT  = 1;
  localparam int unsigned CTL_PCHF_BIT  = 0;
  localparam int unsigned CTL_NFLAGS    = 3;

  // =====================================================
  // peripheral registers and reset values
  localparam int unsigned ADC_BIT       = 6;
  localparam logic [7:0]  CTL_RST       = 8'h00;
  localparam logic [7:0]  PER_RST       = 8'h00;
  localparam logic [7:0]  PER_IMPL_MASK = 8'h40;

  // =====================================================
  // timer rollover and vector
  localparam logic [7:0]  TIMER_MAX     = 8'hFF;
  localparam logic [7:0]  TIMER_ZERO    = 8'h00;
  localparam int unsigned PC_W          = 13;
  localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
  localparam logic [12:0] PC_RST        = 13'h0000;

  // =====================================================
  // sequencer states
  typedef enum logic [1:0] {
    MIL_RUN       = 2'b00,
    MIL_SLEEP     = 2'b01,
    MIL_WAKE_EXEC = 2'b10
  } mil_state_e;

  // =====================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } mil_wr_s;

  typedef struct packed {
    logic sleep;
    logic ret_irq;
    logic instr_done;
  } mil_core_in_s;

  typedef struct packed {
    logic             vector;
    logic             wake;
    logic             asleep;
    logic [PC_W-1:0]  addr;
  } mil_core_out_s;

endpackage

// ==== verilog/mil_edge_sense.sv ====
// registered edge detector over a group of input pins
// assumes the pins are synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
module mil_edge_sense
  import mil_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  // pins and edge choice
  input  wire logic [W-1:0] sig_i,
  input  wire logic         rise_en_i,
  input  wire logic         fall_en_i,
  // one-cycle event
  output logic              event_o
);

  logic [W-1:0] prev_reg;

  // =====================================================
  // previous level; reset loads the pin so no false edge
  always_ff @(posedge core_clk_i) begin
    prev_reg <= sig_i;
  end

  // =====================================================
  // edge pulse
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= |((sig_i & ~prev_reg & {W{rise_en_i}}) |
                   (~sig_i & prev_reg & {W{fall_en_i}}));
    end
  end

endmodule
`default_nettype wire

// ==== verilog/mil_flag_cell.sv ====
// one sticky flag bit, set by hardware, written by software
// assumes set and write arrive as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module mil_flag_cell
  import mil_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // hardware set, software write
  input  wire logic set_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  // flag
  output logic      flag_o
);

  // =====================================================
  // set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (wr_i) begin
      flag_o <= wdata_i;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/mil_irq_logic.sv ====
// interrupt logic of a small 8-bit controller core
// assumes the core executes one instruction cycle per clock edge,
// and that its write strobes and instruction events are synchronous
//
// How it works
// RULE1 - four sources: external edge, timer rollover, port change, converter
// RULE2 - flags set on events regardless of own enable or global enable
// RULE3 - global enable bit 7 passes unmasked interrupts, blocks all when clear
// RULE4 - global enable plus flag and enable set takes the interrupt at once
// RULE5 - every reset clears the global enable
// RULE6 - taking clears global enable, core pushes return address, loads 0004h
// RULE7 - return from interrupt leaves the routine and sets global enable
// RULE8 - software clears serviced flags before re-enabling, else it re-enters
// RULE9 - pin and port events vector within three or four cycles always; here three cycles in run, later when the event wakes the core from sleep
// RULE10 - peripheral flags, enables in own registers, gated by one control bit
// RULE11 - take during global enable clear is undone by return; software retries
// RULE12 - external pin edge is rising when select set, falling when clear
// RULE13 - selected external edge sets flag at control bit 1
// RULE14 - clearing external enable keeps its flag from interrupting
// RULE15 - external pin wakes from sleep only if enabled before sleep
// RULE16 - after interrupt wake, vector only if global enable set
// RULE17 - timer rollover FFh to 00h sets flag at control bit 2
// RULE18 - timer interrupt enable sits at control bit 5
// RULE19 - external, port change and timer flags share the control register
// RULE20 - change on port bits 7 to 4 sets bit 0, own enable gates
// RULE21 - wake with global enable runs the prefetched instruction, then vectors
// RULE22 - peripheral request needs flag, own enable, peripheral enable, global
`timescale 1ns/100ps
`default_nettype none
module mil_irq_logic
  import mil_pkg::*;
#(
  parameter int unsigned PORT_W = 4
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  // interrupt sources
  input  wire logic              ext_irq_pin_i,
  input  wire logic              ext_edge_select_i,
  input  wire logic [PORT_W-1:0] port_hi_i,
  input  wire logic [7:0]        timer_count_i,
  input  wire logic              adc_req_i,
  // software writes
  input  wire mil_wr_s           ctrl_wr_i,
  input  wire mil_wr_s           periph_flag_wr_i,
  input  wire mil_wr_s           periph_enable_wr_i,
  // core sequencing
  input  wire mil_core_in_s      core_i,
  output mil_core_out_s          core_o,
  // register read-back
  output logic [7:0]             irq_control_reg_o,
  output logic [7:0]             periph_flag_reg_o,
  output logic [7:0]             periph_enable_reg_o
);

  // =====================================================
  // helpers

  // field write helper, used for every enable bit of the control register
  function automatic logic wr_bit(input logic old_v,
                                  input mil_wr_s w,
                                  input int unsigned pos);
    logic r;
    r = old_v;
    if (w.wr) begin
      r = w.data[pos];
    end
    return r;
  endfunction

  // any source with flag and gate both set
  function automatic logic any_req(input logic [7:0] flg,
                                   input logic [7:0] ena);
    return |(flg & ena);
  endfunction

  // =====================================================
  // declarations

  mil_state_e           state_reg;
  mil_state_e           state_next;
  logic                 glb_en_reg;
  logic                 peie_reg;
  logic                 tove_reg;
  logic                 exte_reg;
  logic                 pche_reg;
  logic [7:0]           pen_reg;
  logic [7:0]           timer_prev_reg;
  logic                 ext_evt;
  logic                 pch_evt;
  logic                 tov_evt;
  logic [CTL_NFLAGS-1:0] ctl_set;
  logic [CTL_NFLAGS-1:0] ctl_flag;
  logic [7:0]           per_set;
  logic [7:0]           per_flag;
  logic                 core_req;
  logic                 per_req;
  logic                 irq_req;
  logic                 take;
  logic                 sleep_exte_reg;
  logic                 sleep_pche_reg;
  logic                 sleep_per_reg;
  logic                 wake_req;

  // =====================================================
  // source detection

  // RULE12 rising or falling edge
  // RULE1 external source
  mil_edge_sense #(
    .W (1)
  ) u_ext_edge (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .sig_i      (ext_irq_pin_i),
    .rise_en_i  (ext_edge_select_i),
    .fall_en_i  (~ext_edge_select_i),
    .event_o    (ext_evt)
  );

  // RULE20 any change on upper port bits
  // RULE1 port change source
  mil_edge_sense #(
    .W (PORT_W)
  ) u_port_change (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .sig_i      (port_hi_i),
    .rise_en_i  (1'b1),
    .fall_en_i  (1'b1),
    .event_o    (pch_evt)
  );

  // previous timer count for rollover compare
  always_ff @(posedge core_clk_i) begin
    timer_prev_reg <= timer_count_i;
  end

  // RULE17 rollover FFh to 00h
  // RULE1 timer source
  assign tov_evt = (timer_prev_reg == TIMER_MAX) &&
                   (timer_count_i == TIMER_ZERO) && !srst_i;

  // =====================================================
  // control register flags

  // RULE19 three flags in one register
  // RULE13 external flag at bit 1
  always_comb begin
    ctl_set               = '0;
    ctl_set[CTL_PCHF_BIT] = pch_evt;
    ctl_set[CTL_EXTF_BIT] = ext_evt;
    ctl_set[CTL_TOVF_BIT] = tov_evt;
  end

  // RULE2 flags set whatever the enables
  genvar gi;
  generate
    for (gi = 0; gi < CTL_NFLAGS; gi++) begin : g_ctl_flag
      mil_flag_cell u_flag (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .set_i      (ctl_set[gi]),
        .wr_i       (ctrl_wr_i.wr),
        .wdata_i    (ctrl_wr_i.data[gi]),
        .flag_o     (ctl_flag[gi])
      );
    end
  endgenerate

  // =====================================================
  // peripheral flags, only the converter bit is built

  // RULE1 converter source
  // RULE10 peripheral flags in their own register
  always_comb begin
    per_set          = '0;
    per_set[ADC_BIT] = adc_req_i;
  end

  generate
    for (gi = 0; gi < 8; gi++) begin : g_per_flag
      if (PER_IMPL_MASK[gi]) begin : g_impl
        mil_flag_cell u_flag (
          .core_clk_i (core_clk_i),
          .srst_i     (srst_i),
          .set_i      (per_set[gi]),
          .wr_i       (periph_flag_wr_i.wr),
          .wdata_i    (periph_flag_wr_i.data[gi]),
          .flag_o     (per_flag[gi])
        );
      end else begin : g_rsvd
        assign per_flag[gi] = 1'b0;
      end
    end
  endgenerate

  // RULE10 peripheral enables in their own register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pen_reg <= PER_RST;
    end else if (periph_enable_wr_i.wr) begin
      pen_reg <= periph_enable_wr_i.data & PER_IMPL_MASK;
    end
  end

  // =====================================================
  // enable bits of the control register

  // RULE14 external enable
  // RULE18 timer enable at bit 5
  // RULE10 peripheral gate bit
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      peie_reg <= CTL_RST[CTL_PEIE_BIT];
      tove_reg <= CTL_RST[CTL_TOVE_BIT];
      exte_reg <= CTL_RST[CTL_EXTE_BIT];
      pche_reg <= CTL_RST[CTL_PCHE_BIT];
    end else begin
      peie_reg <= wr_bit(peie_reg, ctrl_wr_i, CTL_PEIE_BIT);
      tove_reg <= wr_bit(tove_reg, ctrl_wr_i, CTL_TOVE_BIT);
      exte_reg <= wr_bit(exte_reg, ctrl_wr_i, CTL_EXTE_BIT);
      pche_reg <= wr_bit(pche_reg, ctrl_wr_i, CTL_PCHE_BIT);
    end
  end

  // =====================================================
  // request gating

  // RULE14 external gated by its enable
  // RULE20 port change gated by its enable
  assign core_req = any_req({5'h00, ctl_flag},
                            {5'h00, tove_reg, exte_reg, pche_reg});

  // RULE22 flag, own enable and peripheral gate
  assign per_req = peie_reg & any_req(per_flag, pen_reg);

  // RULE3 global enable passes or blocks all
  assign irq_req = glb_en_reg & (core_req | per_req);

  // RULE4 taken in the same cycle it is seen
  // RULE9 no wait for instruction end
  // a sleep strobe in the same cycle loses to the take
  assign take = irq_req && (state_reg == MIL_RUN);

  // =====================================================
  // global enable

  // RULE5 reset clears it
  // RULE6 taking clears it
  // RULE7 return sets it
  // RULE11 take wins over a clearing write
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      glb_en_reg <= CTL_RST[CTL_GLB_BIT];
    end else if (take) begin
      glb_en_reg <= 1'b0;
    end else if (core_i.ret_irq) begin
      glb_en_reg <= 1'b1;
    end else begin
      glb_en_reg <= wr_bit(glb_en_reg, ctrl_wr_i, CTL_GLB_BIT);
    end
  end

  // =====================================================
  // sleep enable snapshot

  // RULE15 enables as they stood at sleep entry
  // timer cannot wake: it has no clock while asleep
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sleep_exte_reg <= 1'b0;
      sleep_pche_reg <= 1'b0;
      sleep_per_reg  <= 1'b0;
    end else if (core_i.sleep && state_reg == MIL_RUN) begin
      sleep_exte_reg <= exte_reg;
      sleep_pche_reg <= pche_reg;
      sleep_per_reg  <= peie_reg;
    end
  end

  // RULE15 wake needs enable set before sleep
  assign wake_req = (ctl_flag[CTL_EXTF_BIT] & sleep_exte_reg) |
                    (ctl_flag[CTL_PCHF_BIT] & sleep_pche_reg) |
                    (sleep_per_reg & any_req(per_flag, pen_reg));

  // =====================================================
  // sequencer

  // RULE16 vector after wake only with global enable
  // RULE21 prefetched instruction first, then vector
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MIL_RUN: begin
        if (core_i.sleep && !take) begin
          state_next = MIL_SLEEP;
        end
      end
      MIL_SLEEP: begin
        if (wake_req) begin
          state_next = glb_en_reg ? MIL_WAKE_EXEC : MIL_RUN;
        end
      end
      MIL_WAKE_EXEC: begin
        if (core_i.instr_done) begin
          state_next = MIL_RUN;
        end
      end
      default: begin
        state_next = MIL_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= MIL_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================
  // core outputs

  // RULE6 vector pulse with 0004h
  // RULE9 pin event to vector in three cycles
  // wake pulse and sleep level share the process: one writer per struct
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      core_o.vector <= 1'b0;
      core_o.addr   <= PC_RST;
      core_o.wake   <= 1'b0;
      core_o.asleep <= 1'b0;
    end else begin
      core_o.vector <= take;
      core_o.addr   <= IRQ_VECTOR;
      core_o.wake   <= (state_reg == MIL_SLEEP) && wake_req;
      core_o.asleep <= (state_next == MIL_SLEEP);
    end
  end

  // =====================================================
  // register read-back, one cycle behind the state

  // RULE8 software sees flags to clear them
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_control_reg_o   <= CTL_RST;
      periph_flag_reg_o   <= PER_RST;
      periph_enable_reg_o <= PER_RST;
    end else begin
      irq_control_reg_o   <= {glb_en_reg, peie_reg, tove_reg, exte_reg,
                              pche_reg, ctl_flag};
      periph_flag_reg_o   <= per_flag;
      periph_enable_reg_o <= pen_reg;
    end
  end

endmodule
`default_nettype wire

// ==== sim/mil_irq_logic_properties.sv ====
// port relations of the interrupt logic
// assumes the ports of mil_irq_logic and one clock
`timescale 1ns/100ps
`default_nettype none
module mil_irq_chk
  import mil_pkg::*;
#(
  parameter int unsigned PORT_W = 4
) (
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              srst_i,
  // sources
  input wire logic              ext_irq_pin_i,
  input wire logic              ext_edge_select_i,
  input wire logic [PORT_W-1:0] port_hi_i,
  input wire logic [7:0]        timer_count_i,
  // core and images
  input wire mil_core_in_s      core_i,
  input wire mil_core_out_s     core_o,
  input wire logic [7:0]        irq_control_reg_o,
  input wire logic [7:0]        periph_flag_reg_o,
  input wire logic [7:0]        periph_enable_reg_o
);
  // ==========
  // clocking
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  wire logic [7:0] c = irq_control_reg_o;

  // ==========
  // assertions
  a_reset_clears:
  assert property (disable iff (1'b0) srst_i |=> c == CTL_RST && !core_o.vector)
    else $error("reset left enable or vector set");
  a_vector_cause:
  assert property (core_o.vector |-> c[CTL_GLB_BIT] && ((c[1] && c[4]) ||
    (c[2] && c[5]) || (c[0] && c[3]) ||
    (c[6] && periph_flag_reg_o[ADC_BIT] && periph_enable_reg_o[ADC_BIT])))
    else $error("vector without an enabled pending source");
  a_take_clears:
  assert property (core_o.vector |-> core_o.addr == IRQ_VECTOR ##1
    !c[CTL_GLB_BIT] && !core_o.vector) else $error("take did not clear enable");
  a_return_enable:
  assert property (core_i.ret_irq |=> core_o.vector or ##1 c[CTL_GLB_BIT])
    else $error("return did not set enable");
  a_timer_flag:
  assert property (timer_count_i == TIMER_ZERO && $past(timer_count_i) == TIMER_MAX
    |-> ##[1:4] c[CTL_TOVF_BIT]) else $error("rollover flag missing");
  a_ext_edge:
  assert property ((ext_edge_select_i ? $rose(ext_irq_pin_i) : $fell(ext_irq_pin_i))
    |-> ##[1:5] c[CTL_EXTF_BIT]) else $error("pin edge flag missing");
  a_port_flag:
  assert property ($changed(port_hi_i) |-> ##[1:5] c[CTL_PCHF_BIT])
    else $error("port change flag missing");
  a_sleep_enter:
  assert property (core_i.sleep && !core_o.asleep |=> core_o.asleep || core_o.vector)
    else $error("sleep not entered");
  a_wake_pulse:
  assert property (core_o.wake |-> $past(core_o.asleep) && !core_o.asleep
    ##1 !core_o.wake) else $error("bad wake pulse");
  a_no_vec_asleep:
  assert property (core_o.asleep |-> !core_o.vector) else $error("vector while asleep");
endmodule

bind mil_irq_logic mil_irq_chk #(.PORT_W(PORT_W)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ext_irq_pin_i(ext_irq_pin_i),
  .ext_edge_select_i(ext_edge_select_i), .port_hi_i(port_hi_i),
  .timer_count_i(timer_count_i), .core_i(core_i), .core_o(core_o),
  .irq_control_reg_o(irq_control_reg_o), .periph_flag_reg_o(periph_flag_reg_o),
  .periph_enable_reg_o(periph_enable_reg_o)
);
`default_nettype wire

// ==== sim/mil_core_model.sv ====
// processor core sequencing seen from the interrupt logic
// assumes bench requests are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module mil_core_model
  import mil_pkg::*;
#(
  parameter int unsigned DONE_DLY = 3
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          srst_i,
  // bench requests, block answers
  input  wire logic          sleep_req_i,
  input  wire logic          ret_req_i,
  input  wire logic          slow_i,
  input  wire mil_core_out_s blk_i,
  // instruction events
  output var mil_core_in_s   evt_o
);
  logic [3:0] cnt_reg;

  // ==========
  // prefetched instruction runs first
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_reg <= 4'h0;
    end else if (blk_i.wake) begin
      cnt_reg <= slow_i ? 4'(DONE_DLY) : 4'h1;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // ==========
  // return and sleep as pulses
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      evt_o <= '0;
    end else begin
      evt_o.sleep      <= sleep_req_i;
      evt_o.ret_irq    <= ret_req_i;
      evt_o.instr_done <= (cnt_reg == 4'h1);
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench of the interrupt logic
// assumes the core model and checker compile before it
`timescale 1ns/100ps
`default_nettype none
module tb
  import mil_pkg::*;
;
  // ==========
  // stimulus and observation
  localparam logic [15:0] T = 16'h0001;
  logic          core_clk_i;
  logic          srst_i = 1'b1;
  logic          pin = 1'b0;
  logic          sel = 1'b1;
  logic          adc = 1'b0;
  logic          slp = 1'b0;
  logic          ret = 1'b0;
  logic          slow = 1'b0;
  logic [3:0]    port = 4'h0;
  logic [7:0]    tmr = 8'h00;
  mil_wr_s       cw = '0;
  mil_wr_s       fw = '0;
  mil_wr_s       ew = '0;
  mil_core_in_s  cin;
  mil_core_out_s cout;
  logic [7:0]    ctl;
  logic [7:0]    pf;
  logic [7:0]    pe;
  int            failures = 0;
  int            num_checks = 0;
  int            vcnt = 0;
  int            v0;
  int            k;
  int            k_ext;

  mil_irq_logic #(.PORT_W(4)) DUT (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ext_irq_pin_i(pin),
    .ext_edge_select_i(sel), .port_hi_i(port), .timer_count_i(tmr),
    .adc_req_i(adc), .ctrl_wr_i(cw), .periph_flag_wr_i(fw),
    .periph_enable_wr_i(ew), .core_i(cin), .core_o(cout),
    .irq_control_reg_o(ctl), .periph_flag_reg_o(pf), .periph_enable_reg_o(pe)
  );
  mil_core_model #(.DONE_DLY(3)) u_core (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .sleep_req_i(slp),
    .ret_req_i(ret), .slow_i(slow), .blk_i(cout), .evt_o(cin)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (cout.vector === 1'b1) vcnt <= vcnt + 1;
  end

  // ==========
  // tasks
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input int s, input logic [7:0] d);
    @(posedge core_clk_i);
    if (s == 0) cw <= '{wr: 1'b1, data: d};
    else if (s == 1) fw <= '{wr: 1'b1, data: d};
    else ew <= '{wr: 1'b1, data: d};
    @(posedge core_clk_i);
    cw.wr <= 1'b0;
    fw.wr <= 1'b0;
    ew.wr <= 1'b0;
    tick(2);
  endtask
  task automatic pulse(input logic is_ret);
    @(posedge core_clk_i);
    if (is_ret) ret <= 1'b1;
    else slp <= 1'b1;
    @(posedge core_clk_i);
    ret <= 1'b0;
    slp <= 1'b0;
    tick(3);
  endtask
  task automatic wait_for(input logic wake, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (n < 40 && (wake ? cout.wake : cout.vector) !== 1'b1);
  endtask

  // ==========
  // watchdog, far above the under two hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk_i);
    failures++;
    $display("ERROR %0t run did not finish", $time);
    stop_test();
  end

  // ==========
  // tests
  initial begin
    repeat (12) @(posedge core_clk_i);
    srst_i <= 1'b0;
    tick(3);
    chk({pf, pe}, 16'h0000);
    chk({cout.asleep, ctl}, 16'h0000);
    chk(16'(cout.addr), 16'(IRQ_VECTOR));
    wr(0, 8'h90);
    v0 = vcnt;
    @(posedge core_clk_i);
    pin <= 1'b1;
    wait_for(1'b0, k_ext);
    chk(16'(k_ext >= 3 && k_ext <= 4), T);
    chk(16'(cout.addr), 16'(IRQ_VECTOR));
    tick(1);
    chk(16'(ctl), 16'h0012);
    wr(0, 8'h10);
    pulse(1'b1);
    chk(16'(ctl), 16'h0090);
    chk(16'(vcnt - v0), T);
    wr(0, 8'h10);
    @(posedge core_clk_i);
    sel <= 1'b0;
    @(posedge core_clk_i);
    pin <= 1'b0;
    tick(6);
    chk(16'(ctl), 16'h0012);
    wr(0, 8'h82);
    tick(4);
    chk(16'(vcnt - v0), T);
    wr(0, 8'h00);
    @(posedge core_clk_i);
    tmr <= 8'hFF;
    @(posedge core_clk_i);
    tmr <= 8'h00;
    tick(4);
    chk(16'(ctl), 16'h0004);
    wr(0, 8'hA4);
    chk(16'(vcnt - v0), 16'h0002);
    wr(0, 8'h88);
    @(posedge core_clk_i);
    port <= 4'h8;
    wait_for(1'b0, k);
    chk(16'(k), 16'(k_ext));
    wr(2, 8'hFF);
    wr(0, 8'h80);
    v0 = vcnt;
    @(posedge core_clk_i);
    adc <= 1'b1;
    @(posedge core_clk_i);
    adc <= 1'b0;
    tick(4);
    chk({pf, pe}, 16'h4040);
    chk(16'(vcnt - v0), 16'h0000);
    wr(0, 8'hC0);
    chk(16'(vcnt - v0), 16'h0001);
    wr(1, 8'h00);
    @(posedge core_clk_i);
    sel <= 1'b1;
    slow <= 1'b1;
    wr(0, 8'h90);
    pulse(1'b0);
    chk(16'(cout.asleep), T);
    @(posedge core_clk_i);
    pin <= 1'b1;
    wait_for(1'b1, k);
    chk(16'(k < 40), T);
    wait_for(1'b0, k);
    chk(16'(k >= 3 && k < 40), T);
    @(posedge core_clk_i);
    slow <= 1'b0;
    sel <= 1'b0;
    wr(0, 8'h10);
    v0 = vcnt;
    pulse(1'b0);
    @(posedge core_clk_i);
    pin <= 1'b0;
    wait_for(1'b1, k);
    chk(16'(k < 40), T);
    tick(8);
    chk(16'(vcnt - v0), 16'h0000);
    wr(0, 8'h80);
    pulse(1'b0);
    @(posedge core_clk_i);
    port <= 4'h0;
    tick(6);
    chk({7'h00, cout.asleep, ctl}, 16'h0181);
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    tick(2);
    @(posedge core_clk_i);
    srst_i <= 1'b0;
    tick(2);
    chk({7'h00, cout.asleep, ctl}, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
